/* uart_baud_rate_generator.sv */
// baud rate generator with its ahb-lite register slave
//
// Local design decisions: the AHB-Lite slave port and the address map.
`timescale 1ns/1ps
module uart_baud_rate_generator
  import baud_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output logic bitTick
);
  // ****************************************
  // bus slave
  // ****************************************
  logic [7:0] divLow_q;
  logic [7:0] divHigh_q;
  logic sync_q;
  logic highSpeed_q;
  logic wide_q;
  logic wrPend_q;
  logic [7:0] wrAddr_q;
  logic restart_q;
  logic [31:0] rdata_q;
  logic take;
  logic [31:0] readMux;
  logic [31:0] fwdMux;
  baud_cfg_if cfg ();

  // ****************************************
  // address decode helpers
  // ****************************************
  // only the lowest 256 bytes decode; anything above reads zero and drops writes
  function automatic logic low_page(input logic [31:0] a);
    return a[31:8] == 24'h000000;
  endfunction : low_page

  // word a read sees when its address phase meets the data phase of a write to it
  function automatic logic [31:0] written_word(input logic [7:0] a, input logic [31:0] d,
    input logic [31:0] cur);
    logic [31:0] w;
    w = 32'h0000_0000;
    case (a)
      DIV_LOW_ADDR: w[7:0] = d[7:0];
      DIV_HIGH_ADDR: w[7:0] = d[7:0];
      TX_CTRL_ADDR: begin
        w[SYNC_BIT] = d[SYNC_BIT];
        w[HIGH_SPEED_BIT] = d[HIGH_SPEED_BIT];
      end
      BAUD_CTRL_ADDR: w[WIDE_BIT] = d[WIDE_BIT];
      default: w = cur;
    endcase
    return w;
  endfunction : written_word

  function automatic logic [31:0] read_word(input logic [7:0] a);
    logic [31:0] w;
    w = 32'h0000_0000;
    case (a)
      DIV_LOW_ADDR: w[7:0] = divLow_q;
      DIV_HIGH_ADDR: w[7:0] = divHigh_q;
      TX_CTRL_ADDR: begin
        w[SYNC_BIT] = sync_q;
        w[HIGH_SPEED_BIT] = highSpeed_q;
      end
      BAUD_CTRL_ADDR: w[WIDE_BIT] = wide_q;
      COUNT_ADDR: w[15:0] = cfg.countValue;
      default: w = 32'h0000_0000;
    endcase
    return w;
  endfunction : read_word

  assign take = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);
  // a process, not an assign, so register changes reach the mux and not only address changes
  always_comb begin
    readMux = read_word(haddr[7:0]);
    fwdMux = written_word(haddr[7:0], hwdata, readMux);
  end
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rdata_q;

  // address phase capture
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wrPend_q <= 1'b0;
      wrAddr_q <= 8'h00;
      rdata_q <= 32'h0000_0000;
    end else begin
      wrPend_q <= take && hwrite && low_page(haddr);
      if (take) begin
        wrAddr_q <= haddr[7:0];
      end
      if (take && !hwrite) begin
        // back to back: the write landing on this edge must be seen by the read
        rdata_q <= !low_page(haddr) ? 32'h0000_0000
          : (wrPend_q && wrAddr_q == haddr[7:0]) ? fwdMux : readMux;
      end
    end
  end

  // ****************************************
  // configuration registers
  // ****************************************
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      divLow_q <= DIV_RESET;
      divHigh_q <= DIV_RESET;
      sync_q <= 1'b0;
      highSpeed_q <= 1'b0;
      wide_q <= 1'b0;
    end else if (wrPend_q) begin
      case (wrAddr_q)
        DIV_LOW_ADDR: divLow_q <= hwdata[7:0];
        DIV_HIGH_ADDR: divHigh_q <= hwdata[7:0];
        TX_CTRL_ADDR: begin
          sync_q <= hwdata[SYNC_BIT];
          highSpeed_q <= hwdata[HIGH_SPEED_BIT];
        end
        BAUD_CTRL_ADDR: wide_q <= hwdata[WIDE_BIT];
        default: ;
      endcase
    end
  end

  // restart follows the write so the counter reloads the new divisor
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      restart_q <= 1'b1;
    end else begin
      restart_q <= wrPend_q && (wrAddr_q == DIV_LOW_ADDR
        || wrAddr_q == DIV_HIGH_ADDR);
    end
  end

  // ****************************************
  // divisor and factor selection
  // ****************************************
  assign cfg.divisor = wide_q ? {divHigh_q, divLow_q} : {8'h00, divLow_q};
  assign cfg.restart = restart_q;

  always_comb begin
    if (sync_q) begin
      cfg.prescaleLast = FACTOR_4_LAST;
    end else if (highSpeed_q) begin
      cfg.prescaleLast = wide_q ? FACTOR_4_LAST : FACTOR_16_LAST;
    end else if (wide_q) begin
      cfg.prescaleLast = FACTOR_16_LAST;
    end else begin
      cfg.prescaleLast = FACTOR_64_LAST;
    end
  end

  baud_counter baud_counter_inst (
    .clk(clk),
    .reset(reset),
    .cfg(cfg)
  );

  assign bitTick = cfg.tick;
endmodule : uart_baud_rate_generator

/* baud_pkg.sv */
// constants for the baud rate generator and its register map
package baud_pkg;
  // ****************************************
  // register byte addresses
  // ****************************************
  localparam logic [7:0] DIV_LOW_ADDR = 8'h00;
  localparam logic [7:0] DIV_HIGH_ADDR = 8'h04;
  localparam logic [7:0] TX_CTRL_ADDR = 8'h08;
  localparam logic [7:0] BAUD_CTRL_ADDR = 8'h0c;
  localparam logic [7:0] COUNT_ADDR = 8'h10;
  // ****************************************
  // field positions and reset values
  // ****************************************
  localparam int SYNC_BIT = 4;
  localparam int HIGH_SPEED_BIT = 2;
  localparam int WIDE_BIT = 3;
  localparam logic [7:0] DIV_RESET = 8'h00;
  // ****************************************
  // divide factors, stored as terminal count (factor minus one), then the htrans codes
  // ****************************************
  localparam logic [5:0] FACTOR_64_LAST = 6'h3f;
  localparam logic [5:0] FACTOR_16_LAST = 6'h0f;
  localparam logic [5:0] FACTOR_4_LAST = 6'h03;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ = 2'h3;
endpackage : baud_pkg

/* baud_cfg_if.sv */
// carrier between the register file and the baud counter
`timescale 1ns/1ps
interface baud_cfg_if;
  logic [15:0] divisor;
  logic [5:0] prescaleLast;
  logic restart;
  logic tick;
  logic [15:0] countValue;
  modport ctrl (output divisor, output prescaleLast, output restart, input tick, input countValue);
  modport counter (input divisor, input prescaleLast, input restart, output tick,
    output countValue);
endinterface : baud_cfg_if

/* baud_counter.sv */
// two-stage counter producing one tick per bit period
`timescale 1ns/1ps
module baud_counter
  import baud_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  baud_cfg_if.counter cfg
);
  logic [5:0] pre_q;
  logic [15:0] div_q;
  logic tick_q;

  // prescale stage: factor cycles per divisor step
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pre_q <= 6'h00;
    end else if (cfg.restart || pre_q >= cfg.prescaleLast) begin
      pre_q <= 6'h00;
    end else begin
      pre_q <= pre_q + 6'h01;
    end
  end

  // divisor stage: n+1 steps per bit period
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      div_q <= 16'h0000;
      tick_q <= 1'b0;
    end else if (cfg.restart) begin
      div_q <= cfg.divisor;
      tick_q <= 1'b0;
    end else if (pre_q >= cfg.prescaleLast) begin
      tick_q <= (div_q == 16'h0000);
      div_q <= (div_q == 16'h0000) ? cfg.divisor : div_q - 16'h0001;
    end else begin
      tick_q <= 1'b0;
    end
  end

  assign cfg.tick = tick_q;
  assign cfg.countValue = div_q;
endmodule : baud_counter

/* uart_baud_rate_generator_chk.sv */
// port assertions for the baud rate generator
`timescale 1ns/1ps
module uart_baud_rate_generator_chk
  import baud_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic bitTick
);
  logic ap, w, ok, dl, dh, sy, hs, wd;
  logic [7:0] a, lo, hi, tc, bc;
  int gap, f, p;
  assign sy = tc[SYNC_BIT];
  assign hs = tc[HIGH_SPEED_BIT];
  assign wd = bc[WIDE_BIT];
  assign f = sy ? 4 : (hs ? 4 : 16) * (wd ? 1 : 4);
  assign p = f * ((wd ? {hi, lo} : {8'h0, lo}) + 1);
  // ****
  // register mirror and tick spacing
  // ****
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      {ap, w, ok, dl, dh, a, lo, hi, tc, bc} <= '0;
      gap <= 0;
    end else begin
      ap <= hsel && hready && htrans[1];
      w <= hwrite;
      a <= haddr[7:0];
      gap <= gap + 1;
      if (ap && w) begin
        {ok, gap} <= '0;
        dl <= a == DIV_LOW_ADDR;
        dh <= a == DIV_HIGH_ADDR;
        if (a == DIV_LOW_ADDR) lo <= hwdata[7:0];
        if (a == DIV_HIGH_ADDR) hi <= hwdata[7:0];
        if (a == TX_CTRL_ADDR) tc <= hwdata[7:0];
        if (a == BAUD_CTRL_ADDR) bc <= hwdata[7:0];
      end else if (bitTick && gap > 2) begin
        {ok, dl, dh} <= 3'h4;
        gap <= 1;
      end
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  sequence settled; bitTick && ok; endsequence
  sequence restarted; bitTick && !ok && gap > 2; endsequence
  slow_narrow_a: assert property (settled ##0 (!sy && !hs && !wd) |-> gap == 64 * (lo + 1))
    else $error("narrow normal period wrong");
  slow_wide_a: assert property (settled ##0 (!sy && !hs && wd) |-> gap == 16 * ({hi, lo} + 1))
    else $error("wide normal period wrong");
  sync_rate_a: assert property (settled ##0 sy |-> gap == 4 * ((wd ? {hi, lo} : {8'h0, lo}) + 1))
    else $error("sync period wrong");
  fast_rate_a: assert property (settled ##0 (!sy && hs) |-> gap == (wd ? 4 : 16) * (wd ? {hi, lo} + 1 : lo + 1))
    else $error("high speed period wrong");
  high_ignored_a: assert property (settled ##0 !wd |-> gap == f * (lo + 1))
    else $error("high byte not ignored");
  pair_divisor_a: assert property (settled ##0 wd |-> gap == f * ({hi, lo} + 1))
    else $error("divisor pair wrong");
  low_restart_a: assert property (restarted ##0 dl |-> gap inside {[p - 1:p + 3]})
    else $error("low write did not restart");
  high_restart_a: assert property (restarted ##0 dh |-> gap inside {[p - 1:p + 3]})
    else $error("high write did not restart");
  high_readback_a: assert property (ap && !w && a == DIV_HIGH_ADDR |-> hrdata == {24'h0, hi})
    else $error("high byte readback wrong");
  bus_okay_a: assert property (hreadyout && !hresp)
    else $error("bus answer not ready okay");
endmodule : uart_baud_rate_generator_chk
bind uart_baud_rate_generator uart_baud_rate_generator_chk uart_baud_rate_generator_chk_inst (
  .clk(clk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .bitTick(bitTick));

/* test_uart_baud_rate_generator.sv */
// self-checking bench for the baud rate generator
`timescale 1ns/1ps
module test_uart_baud_rate_generator;
  import baud_pkg::*;
  logic clk = 0, reset = 1, hsel = 0, hwrite = 0, bitTick, hreadyout, hresp;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  int miscompares = 0, checked = 0, cyc = 0;
  always #10 clk = ~clk;
  uart_baud_rate_generator uart_baud_rate_generator_inst (.clk(clk), .reset(reset), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .bitTick(bitTick));
  // ****
  // bus, compare and closing tasks
  // ****
  task automatic xfer(input logic [7:0] ad, input logic wr, input logic [31:0] wd);
    @(posedge clk);
    {hsel, hwrite, htrans, haddr} <= {1'b1, wr, HTRANS_NONSEQ, 24'h0, ad};
    do @(posedge clk); while (hreadyout !== 1'b1);
    {hsel, htrans, hwdata} <= {1'b0, 2'h0, wd};
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : xfer
  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask : cmp
  task automatic cmpr(input string nm, input int lo, input int hi, input int g);
    checked++;
    if (g < lo || g > hi) begin
      miscompares++;
      $display("BAD %s exp %0d..%0d got %0d", nm, lo, hi, g);
    end
  endtask : cmpr
  task automatic tick_gap(output int c);
    c = 0;
    do begin
      @(negedge clk);
      c++;
    end while (bitTick !== 1'b1);
  endtask : tick_gap
  task automatic cfg(input int t, input int b, input int h, input int l);
    xfer(TX_CTRL_ADDR, 1, t);
    xfer(BAUD_CTRL_ADDR, 1, b);
    xfer(DIV_HIGH_ADDR, 1, h);
    xfer(DIV_LOW_ADDR, 1, l);
  endtask : cfg
  task automatic wrap_up;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : wrap_up
  task automatic t_regs;
    xfer(DIV_HIGH_ADDR, 0, 32'h0);
    cmp("high reset", {24'h0, DIV_RESET}, rd);
    xfer(DIV_HIGH_ADDR, 1, 32'ha5);
    xfer(DIV_HIGH_ADDR, 0, 32'h0);
    cmp("high rw", 32'ha5, rd);
    xfer(8'h40, 0, 32'h0);
    cmp("unmapped", 32'h0, rd);
  endtask : t_regs
  task automatic t_modes;
    int c;
    int tab [6][5] = '{'{0, 0, 1, 2, 192}, '{0, 8, 0, 3, 64}, '{4, 0, 1, 1, 32},
      '{4, 8, 1, 0, 1028}, '{16, 0, 1, 4, 20}, '{20, 8, 0, 5, 24}};
    for (int i = 0; i < 6; i++) begin
      cfg(tab[i][0], tab[i][1], tab[i][2], tab[i][3]);
      repeat (3) tick_gap(c);
      cmpr("mode period", tab[i][4], tab[i][4], c);
    end
  endtask : t_modes
  task automatic t_restart;
    int c;
    cfg(0, 8, 0, 9);
    tick_gap(c);
    repeat (50) @(posedge clk);
    xfer(DIV_LOW_ADDR, 1, 32'h9);
    tick_gap(c);
    cmpr("low restart", 159, 163, c);
    repeat (50) @(posedge clk);
    xfer(DIV_HIGH_ADDR, 1, 32'h0);
    tick_gap(c);
    cmpr("high restart", 159, 163, c);
  endtask : t_restart
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      miscompares++;
      wrap_up;
    end
  end
  initial begin
    repeat (8) @(posedge clk);
    reset <= 0;
    t_regs;
    t_modes;
    t_restart;
    wrap_up;
  end
endmodule : test_uart_baud_rate_generator
